// [bench/scil_host_model.sv]
// Purpose: Host model reaching the block over Wishbone
// Assumes: Classic single cycles, one at a time
// Notes:   Released lines carry the inverse of the last request
`timescale 1ns/100ps
module scil_host_model (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    // Bus
    output scil_pkg::scil_wb_req_t      wb_req,
    input  wire logic [31:0]            wb_dat_o,
    input  wire logic                   wb_ack_o,
    // Interrupt
    input  wire logic                   irq_n_o
);
    import scil_pkg::*;
    initial wb_req = '0;
    // ----------------------------------------
    // Bus cycle
    // ----------------------------------------
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        output logic [31:0] rd);
        scil_wb_req_t r;
        r = '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        @(posedge clk_sys);
        wb_req <= r;
        // Only ack ends a wait; a lost ack runs into the bench timeout
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        r = ~r;  // Stale values would hide decode slips
        r.cyc = 1'b0;
        r.stb = 1'b0;
        wb_req <= r;
    endtask
    // ----------------------------------------
    // Interrupt service
    // ----------------------------------------
    task automatic service(output logic [15:0] st);
        logic [31:0] d;
        st = '0;
        if (rst_b === 1'b1 && irq_n_o === 1'b0) begin
            for (int w = 0; w < 4; w++) begin
                xfer(1'b0, 8'(w * 4), 32'h0000_0000, d);
                st[w*4 +: 4] = d[3:0];
            end
        end
    endtask
endmodule // scil_host_model

// [bench/slic_codec_interrupt_logic_tb_top.sv]
// Purpose: Self-checking bench for the interrupt block
// Assumes: Integer model of flags and enables
// Notes:   Events are one-cycle pulses
`timescale 1ns/100ps
module slic_codec_interrupt_logic_tb_top;
    import scil_pkg::*;
    logic         clk_sys = 1'b0;
    logic         rst_b = 1'b0;
    scil_wb_req_t wb_req;
    scil_evt_t    evt_in = '0;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o;
    logic         irq_n_o;
    logic         irq_o;
    int           error_cnt = 0;
    int           checked = 0;
    int           cycles = 0;
    int           flags_m = 0;
    logic [31:0]  lfsr = 32'hbc68;
    logic [31:0]  rd;
    logic [15:0]  st;

    initial forever #12.5 clk_sys = ~clk_sys;

    scil_irq_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .evt_in(evt_in),
        .irq_n_o(irq_n_o), .irq_o(irq_o));
    scil_host_model host (.clk_sys(clk_sys), .rst_b(rst_b), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_n_o(irq_n_o));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
            error_cnt++;
        end
    endtask
    task automatic chk_irq();
        #1;
        chk({31'h0, irq_n_o}, {31'h0, flags_m == 0}, "irq_n");
        chk({31'h0, irq_o}, {31'h0, flags_m != 0}, "irq");
    endtask
    task automatic pulse(input logic [15:0] e, input logic [15:0] en);
        @(posedge clk_sys);
        evt_in <= e;
        flags_m |= int'(e & en);  // Masked events are dropped
        @(posedge clk_sys);
        evt_in <= '0;
        chk_irq();
    endtask
    task automatic rd_st(input int w);
        host.xfer(1'b0, 8'(w * 4), 32'h0, rd);
        chk(rd, 32'((flags_m >> (4 * w)) & 'hf), "status");
        flags_m &= ~('hf << (4 * w));
        chk_irq();
    endtask
    task automatic set_en(input logic [15:0] v);
        host.xfer(1'b1, SCIL_OFS_EN1, {26'h0, v[5:0]}, rd);
        host.xfer(1'b1, SCIL_OFS_EN2, {26'h0, v[11:6]}, rd);
        host.xfer(1'b1, SCIL_OFS_EN3, {28'h0, v[15:12]}, rd);
        host.xfer(1'b0, SCIL_OFS_EN1, 32'h0, rd);
        chk(rd, {26'h0, v[5:0]}, "en1");
        host.xfer(1'b0, SCIL_OFS_EN2, 32'h0, rd);
        chk(rd, {26'h0, v[11:6]}, "en2");
        host.xfer(1'b0, SCIL_OFS_EN3, 32'h0, rd);
        chk(rd, {28'h0, v[15:12]}, "en3");
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [15:0] en;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            host.xfer(1'b0, 8'(a * 4), 32'h0, rd);
            chk(rd, 32'h0, "reset reg");
        end
        chk_irq();
        // Every source alone, then a read of its own status word clears it
        set_en(16'hffff);
        for (int i = 0; i < 16; i++) begin
            pulse(16'(1 << i), 16'hffff);
            rd_st(i / 4);
        end
        pulse(16'h0011, 16'hffff);
        rd_st(0);
        rd_st(1);
        // Event in the clearing cycle survives
        pulse(16'h0002, 16'hffff);
        fork
            host.xfer(1'b0, SCIL_OFS_ST0, 32'h0, rd);
            begin
                @(posedge clk_sys);
                evt_in <= 16'h0001;
                @(posedge clk_sys);
                evt_in <= '0;
            end
        join
        chk(rd, 32'h2, "race read");
        flags_m = 1;
        chk_irq();
        rd_st(0);
        // Unmapped place and clear word
        host.xfer(1'b1, 8'h20, 32'hffff_ffff, rd);
        host.xfer(1'b0, 8'h20, 32'h0, rd);
        chk(rd, 32'h0, "unmapped");
        pulse(16'hffff, 16'hffff);
        host.xfer(1'b1, SCIL_OFS_CLR, 32'h0000_0f0f, rd);
        flags_m &= ~'h0f0f;
        chk_irq();
        host.service(st);
        chk({16'h0, st}, 32'(flags_m), "service");
        flags_m = 0;
        pulse(16'h8001, 16'hffff);
        host.xfer(1'b1, SCIL_OFS_CLR, 32'h0000_ffff, rd);
        flags_m = 0;
        chk_irq();
        // Random masks and events
        for (int k = 0; k < 40; k++) begin
            en = 16'(rnd());
            set_en(en);
            pulse(16'(rnd()), en);
            host.service(st);
            chk({16'h0, st}, 32'(flags_m), "random");
            flags_m = 0;
            chk_irq();
        end
        // Reset in mid-run drops flags and enables
        set_en(16'hffff);
        pulse(16'h0f00, 16'hffff);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        flags_m = 0;
        chk_irq();
        host.xfer(1'b0, SCIL_OFS_ST2, 32'h0, rd);
        chk(rd, 32'h0, "reset st2");
        host.xfer(1'b0, SCIL_OFS_EN1, 32'h0, rd);
        chk(rd, 32'h0, "reset en1");
        summarize();
    end
endmodule // slic_codec_interrupt_logic_tb_top

// [common/scil_pkg.sv]
// Purpose: Shared constants and types for the interrupt aggregation block
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes:   Sixteen event sources, four status words, three enable words
package scil_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int          SCIL_NUM_SRC   = 16;
    localparam int          SCIL_ST_W      = 4;
    localparam int          SCIL_EN1_W     = 6;
    localparam int          SCIL_EN2_W     = 6;
    localparam int          SCIL_EN3_W     = 4;
    localparam int          SCIL_ADR_W     = 8;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0]  SCIL_OFS_ST0   = 8'h00;
    localparam logic [7:0]  SCIL_OFS_ST1   = 8'h04;
    localparam logic [7:0]  SCIL_OFS_ST2   = 8'h08;
    localparam logic [7:0]  SCIL_OFS_ST3   = 8'h0c;
    localparam logic [7:0]  SCIL_OFS_EN1   = 8'h10;
    localparam logic [7:0]  SCIL_OFS_EN2   = 8'h14;
    localparam logic [7:0]  SCIL_OFS_EN3   = 8'h18;
    localparam logic [7:0]  SCIL_OFS_CLR   = 8'h1c;

    // ----------------------------------------
    // Field positions inside the source vector
    // ----------------------------------------
    localparam int          SCIL_EN2_POS   = 6;
    localparam int          SCIL_EN3_POS   = 12;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] SCIL_RST_ST    = 16'h0000;
    localparam logic [5:0]  SCIL_RST_EN1   = 6'h00;
    localparam logic [5:0]  SCIL_RST_EN2   = 6'h00;
    localparam logic [3:0]  SCIL_RST_EN3   = 4'h0;
    localparam logic [31:0] SCIL_RST_DAT   = 32'h0000_0000;

    // ----------------------------------------
    // Event sources, bit 0 is the last field
    // ----------------------------------------
    typedef struct packed {
        logic tx_modem_tone;
        logic rx_modem_tone;
        logic ram_access_done;
        logic pm_inactive_tmr;
        logic pm_active_tmr;
        logic ring_inactive_tmr;
        logic ring_active_tmr;
        logic inactive_tmr2;
        logic active_tmr2;
        logic inactive_tmr1;
        logic active_tmr1;
        logic dtmf_digit;
        logic power_alarm;
        logic ground_key;
        logic ring_trip;
        logic loop_ring_gnd;
    } scil_evt_t;

    // ----------------------------------------
    // Wishbone request from the master
    // ----------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } scil_wb_req_t;

endpackage

// [verilog/scil_irq_ctrl.sv]
// Purpose: Interrupt aggregation with clear-on-read pending flags
// Assumes: Event inputs come from logic on clk_sys
// Notes:   An event input held high keeps setting its enabled flag
//
// Function
// R1: Sixteen named event sources feed the block
// R2: Four status words hold four pending bits each, one per source
// R3: Three enable words, one means enabled
// R4: Only an enabled event sets its flag
// R5: Interrupt pin low while any flag set
// R6: Reading a status word clears its bits
// R7: Pin stays asserted while flags remain
// R8: Host reads status words to find sources
// R9: Event in clearing cycle keeps flag set
`timescale 1ns/100ps
module scil_irq_ctrl (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    // Wishbone slave
    input  wire scil_pkg::scil_wb_req_t wb_req,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    // Event sources
    input  wire scil_pkg::scil_evt_t    evt_in,
    // Interrupt outputs
    output logic                        irq_n_o,
    output logic                        irq_o
);
    import scil_pkg::*;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic is_status(input logic [7:0] a);
        is_status = (a == SCIL_OFS_ST0) || (a == SCIL_OFS_ST1) ||
                    (a == SCIL_OFS_ST2) || (a == SCIL_OFS_ST3);
    endfunction

    function automatic logic [1:0] status_idx(input logic [7:0] a);
        status_idx = a[3:2];
    endfunction

    function automatic logic [15:0] word_mask(input logic [1:0] k);
        word_mask = 16'h000f << {k, 2'b00};
    endfunction

    function automatic logic [3:0] status_word(input logic [15:0] s, input logic [1:0] k);
        status_word = s[{k, 2'b00} +: 4];
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [15:0] status_reg;
    logic [15:0] status_next;
    logic [5:0]  en1_reg;
    logic [5:0]  en1_next;
    logic [5:0]  en2_reg;
    logic [5:0]  en2_next;
    logic [3:0]  en3_reg;
    logic [3:0]  en3_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic        irq_n_reg;
    logic        irq_n_next;
    logic        irq_reg;

    logic        take;
    logic        rd_take;
    logic        wr_take;
    logic        ack;

    logic [15:0] evt_vec;
    logic [15:0] en_vec;
    logic [15:0] set_vec;
    logic [15:0] rd_clr_vec;
    logic [15:0] wr_clr_vec;
    logic [15:0] clr_vec;
    logic [1:0]  st_word;
    logic [7:0]  adr;
    logic        hit_st;
    logic        hit_en1;
    logic        hit_en2;
    logic        hit_en3;
    logic        hit_clr;
    logic        wr_lane0;
    logic        wr_lane1;

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    scil_wb_slave u_slave (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wb_req  (wb_req),
        .take    (take),
        .rd_take (rd_take),
        .wr_take (wr_take),
        .ack_o   (ack)
    );

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    assign adr      = wb_req.adr;
    assign hit_st   = is_status(adr);
    assign hit_en1  = (adr == SCIL_OFS_EN1);
    assign hit_en2  = (adr == SCIL_OFS_EN2);
    assign hit_en3  = (adr == SCIL_OFS_EN3);
    assign hit_clr  = (adr == SCIL_OFS_CLR);
    assign wr_lane0 = wr_take & wb_req.sel[0];
    assign wr_lane1 = wr_take & wb_req.sel[1];

    // ----------------------------------------
    // Enable words
    // ----------------------------------------
    assign en1_next = (wr_lane0 && hit_en1) ? wb_req.dat[5:0] : en1_reg; // [R3]
    assign en2_next = (wr_lane0 && hit_en2) ? wb_req.dat[5:0] : en2_reg; // [R3]
    assign en3_next = (wr_lane0 && hit_en3) ? wb_req.dat[3:0] : en3_reg; // [R3]
    assign en_vec   = {en3_reg, en2_reg, en1_reg};

    // ----------------------------------------
    // Pending flags
    // ----------------------------------------
    assign evt_vec    = evt_in;                                   // [R1]
    // Gating at the set keeps masked sources out of the flags entirely
    assign set_vec    = evt_vec & en_vec;                         // [R4]
    assign st_word    = status_idx(adr);
    assign rd_clr_vec = (rd_take && hit_st) ? word_mask(st_word) : 16'h0000; // [R6]
    assign wr_clr_vec = (wr_take && hit_clr) ?
                        ({{8{wr_lane1}}, {8{wr_lane0}}} & wb_req.dat[15:0]) :
                        16'h0000;
    assign clr_vec    = rd_clr_vec | wr_clr_vec;
    // Set after clear so a simultaneous event survives
    assign status_next = (status_reg & ~clr_vec) | set_vec;      // [R2] [R9]

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Captured from the pre-clear value, so the read shows what it clears
    assign dat_next =
        !rd_take ? SCIL_RST_DAT :
        hit_st   ? {28'h0000000, status_word(status_reg, st_word)} :      // [R2]
        hit_en1  ? {26'h0000000, en1_reg} :
        hit_en2  ? {26'h0000000, en2_reg} :
        hit_en3  ? {28'h0000000, en3_reg} :
        SCIL_RST_DAT;

    // ----------------------------------------
    // Interrupt pin
    // ----------------------------------------
    assign irq_n_next = ~|status_next;                           // [R5] [R7]

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            status_reg <= SCIL_RST_ST;
            en1_reg    <= SCIL_RST_EN1;
            en2_reg    <= SCIL_RST_EN2;
            en3_reg    <= SCIL_RST_EN3;
        end else begin
            status_reg <= status_next;
            en1_reg    <= en1_next;
            en2_reg    <= en2_next;
            en3_reg    <= en3_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dat_reg   <= SCIL_RST_DAT;
            irq_n_reg <= 1'b1;
            irq_reg   <= 1'b0;
        end else begin
            dat_reg   <= dat_next;
            irq_n_reg <= irq_n_next;
            irq_reg   <= ~irq_n_next;
        end
    end

    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack;
    assign irq_n_o  = irq_n_reg;
    assign irq_o    = irq_reg;

    // ----------------------------------------
    // Assertion helpers
    // ----------------------------------------
    logic [15:0] chk_set;
    logic [15:0] chk_clr_rd;
    logic [3:0]  chk_word;
    logic        chk_rd_st;
    logic        chk_wr_en1;
    logic [5:0]  chk_en1_dat;
    logic        chk_rd_none;
    logic        chk_wr_clr;

    assign chk_set     = set_vec;
    assign chk_clr_rd  = rd_clr_vec;
    assign chk_word    = status_word(status_reg, st_word);
    assign chk_rd_st   = rd_take & hit_st;
    assign chk_wr_en1  = wr_lane0 & hit_en1;
    assign chk_en1_dat = wb_req.dat[5:0];
    assign chk_rd_none = rd_take & ~(hit_st | hit_en1 | hit_en2 | hit_en3);
    assign chk_wr_clr  = wr_take & hit_clr;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood for more than one cycle");

    a_masked_no_set: assert property ( // [R4]
        ##1 (status_reg & ~$past(status_reg) & ~$past(en_vec)) == 16'h0000)
        else $error("masked source set its pending flag");

    a_enabled_sets_flag: assert property ( // [R4]
        (chk_set != 16'h0000) |=> ((status_reg & $past(chk_set)) == $past(chk_set)))
        else $error("enabled event did not set its flag");

    a_read_clears_word: assert property ( // [R6]
        chk_rd_st |=> ((status_reg & $past(chk_clr_rd) & ~$past(chk_set)) == 16'h0000))
        else $error("status read left bits set");

    a_event_beats_clear: assert property ( // [R9]
        (chk_rd_st && ((chk_set & chk_clr_rd) != 16'h0000))
        |=> ((status_reg & $past(chk_set)) == $past(chk_set)))
        else $error("event lost during clearing read");

    a_read_returns_word: assert property ( // [R2]
        chk_rd_st |=> (wb_ack_o && wb_dat_o == {28'h0000000, $past(chk_word)}))
        else $error("status read returned wrong data");

    a_pin_is_nor: assert property ( // [R5]
        (irq_n_o == (status_reg == 16'h0000)) && (irq_o != irq_n_o))
        else $error("interrupt pin does not follow flags");

    a_pin_holds_after_read: assert property ( // [R7]
        (chk_rd_st && ((status_reg & ~chk_clr_rd) != 16'h0000)) |=> !irq_n_o [*2])
        else $error("interrupt pin released with flags still set");

    a_enable_write: assert property ( // [R3]
        chk_wr_en1 |=> (en1_reg == $past(chk_en1_dat)))
        else $error("enable word not written");

    a_enable_write_mid: assert property ( // [R3]
        (wr_lane0 && hit_en2) |=> (en2_reg == $past(wb_req.dat[5:0])))
        else $error("middle enable word not written");

    a_enable_write_top: assert property ( // [R3]
        (wr_lane0 && hit_en3) |=> (en3_reg == $past(wb_req.dat[3:0])))
        else $error("top enable word not written");

    a_enables_hold: assert property ( // [R3]
        !wr_take |=> (en_vec == $past(en_vec)))
        else $error("enable words changed without a write");

    // ----------------------------------------
    // Bus assertions
    // ----------------------------------------
    a_ack_after_take: assert property (
        take |=> wb_ack_o)
        else $error("taken request not acknowledged");

    a_ack_needs_request: assert property (
        wb_ack_o |-> $past(wb_req.cyc && wb_req.stb))
        else $error("ack without a request");

    // Zero outside ack keeps stale words off a shared bus
    a_dat_idle_zero: assert property (
        !wb_ack_o |-> (wb_dat_o == SCIL_RST_DAT))
        else $error("read data not zero outside ack");

    a_write_no_data: assert property (
        wr_take |=> (wb_dat_o == SCIL_RST_DAT))
        else $error("write returned read data");

    a_unmapped_reads_zero: assert property (
        chk_rd_none |=> (wb_dat_o == SCIL_RST_DAT))
        else $error("unmapped read returned data");

    a_read_en_low: assert property ( // [R3]
        (rd_take && hit_en1) |=> (wb_dat_o == {26'h0, $past(en1_reg)}))
        else $error("low enable word read wrong");

    a_read_en_mid: assert property ( // [R3]
        (rd_take && hit_en2) |=> (wb_dat_o == {26'h0, $past(en2_reg)}))
        else $error("middle enable word read wrong");

    a_read_en_top: assert property ( // [R3]
        (rd_take && hit_en3) |=> (wb_dat_o == {28'h0, $past(en3_reg)}))
        else $error("top enable word read wrong");

    // ----------------------------------------
    // Flag assertions
    // ----------------------------------------
    // Only a clearing access may drop a flag
    a_flags_sticky: assert property ( // [R2]
        ##1 (($past(status_reg) & ~status_reg & ~$past(clr_vec)) == 16'h0000))
        else $error("pending flag fell without a clearing access");

    a_idle_no_set: assert property ( // [R4]
        (evt_vec == 16'h0000) |=> ((status_reg & ~$past(status_reg)) == 16'h0000))
        else $error("flag set with no event");

    a_clear_write_clears: assert property (
        chk_wr_clr |=> ((status_reg & $past(wr_clr_vec) & ~$past(set_vec)) == 16'h0000))
        else $error("clear write left bits set");

    a_read_keeps_others: assert property ( // [R6]
        chk_rd_st |=> (($past(status_reg) & ~$past(chk_clr_rd) & ~status_reg) == 16'h0000))
        else $error("status read cleared another word");

    a_write_keeps_flags: assert property ( // [R6]
        (wr_take && !hit_clr) |=> (($past(status_reg) & ~status_reg) == 16'h0000))
        else $error("write other than clear dropped a flag");

    // ----------------------------------------
    // Pin assertions
    // ----------------------------------------
    a_pin_falls_on_set: assert property ( // [R5]
        (set_vec != 16'h0000) |=> (!irq_n_o && irq_o))
        else $error("enabled event did not assert the pin");

    a_pin_released_empty: assert property ( // [R5]
        (chk_rd_st && ((status_reg & ~chk_clr_rd) == 16'h0000) && (set_vec == 16'h0000))
        |=> irq_n_o)
        else $error("pin held with no flags left");

    a_pin_quiet_idle: assert property ( // [R4]
        ((status_reg == 16'h0000) && (set_vec == 16'h0000)) |=> irq_n_o)
        else $error("pin asserted with no enabled event");

    c_flag_raised: cover property (irq_n_o ##1 !irq_n_o);
    c_read_releases_pin: cover property (chk_rd_st ##1 irq_n_o);
    c_event_during_clear: cover property (chk_rd_st && ((chk_set & chk_clr_rd) != 16'h0000));
    c_clear_reg_write: cover property (wr_take && hit_clr && !irq_n_o ##1 irq_n_o);
    c_masked_event: cover property ((evt_vec & ~en_vec) != 16'h0000);

endmodule // scil_irq_ctrl

// [verilog/scil_wb_slave.sv]
// Purpose: Wishbone classic handshake for the interrupt block
// Assumes: Master holds the request until it sees ack
// Notes:   One wait state, ack stands one cycle
`timescale 1ns/100ps
module scil_wb_slave (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    // Bus request
    input  wire scil_pkg::scil_wb_req_t wb_req,
    // Access strobes
    output logic                      take,
    output logic                      rd_take,
    output logic                      wr_take,
    output logic                      ack_o
);
    import scil_pkg::*;

    logic ack_reg;
    logic ack_next;

    // ----------------------------------------
    // Handshake
    // ----------------------------------------
    // Masking with ack_reg keeps a held request from being taken twice
    assign take     = wb_req.cyc & wb_req.stb & ~ack_reg;
    assign rd_take  = take & ~wb_req.we;
    assign wr_take  = take & wb_req.we;
    assign ack_next = take;
    assign ack_o    = ack_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
        end
    end

endmodule // scil_wb_slave
